//--- rtl/ebt_pkg.sv
// constants and register map of the 8-bit capture/compare timer
package ebt_pkg;

   localparam int unsigned AW = 4;
   localparam int unsigned DW = 8;

   localparam logic [AW-1:0] OFF_STATUS = 4'h0;
   localparam logic [AW-1:0] OFF_CAP1   = 4'h1;
   localparam logic [AW-1:0] OFF_CMP1   = 4'h2;
   localparam logic [AW-1:0] OFF_CMP2   = 4'h3;
   localparam logic [AW-1:0] OFF_MAIN   = 4'h4;
   localparam logic [AW-1:0] OFF_ALT    = 4'h5;
   localparam logic [AW-1:0] OFF_CAP2   = 4'h6;
   localparam logic [AW-1:0] OFF_CTRL   = 4'h7;
   localparam logic [AW-1:0] OFF_IRQ_ST = 4'h8;
   localparam logic [AW-1:0] OFF_IRQ_EN = 4'h9;
   localparam logic [AW-1:0] OFF_IRQ_CL = 4'hA;

   // event index inside the 5-bit flag vector; status bit = index + FLAG_LSB
   localparam int unsigned NEV      = 5;
   localparam int unsigned FLAG_LSB = 3;
   localparam int unsigned EV_CAP1  = 4;
   localparam int unsigned EV_CMP1  = 3;
   localparam int unsigned EV_WRAP  = 2;
   localparam int unsigned EV_CAP2  = 1;
   localparam int unsigned EV_CMP2  = 0;
   localparam int unsigned FREEZE_BIT = 2;
   localparam int unsigned PWM_BIT    = 0;

   localparam logic [DW-1:0] STATUS_RST = 8'h00;
   localparam logic [DW-1:0] CNT_RST    = 8'hFC;
   localparam logic [DW-1:0] CNT_MAX    = 8'hFF;
   localparam logic [DW-1:0] CMP_RST    = 8'h00;

   localparam int unsigned PRESC_DIV_DEF = 4;

endpackage : ebt_pkg

//--- rtl/ebt_timer.sv
// 8-bit free-running timer with two captures, two compares and flags
`timescale 1ns/100ps
module ebt_timer #(
   parameter int unsigned PRESC_DIV = ebt_pkg::PRESC_DIV_DEF
) (
   input  wire logic                     ref_clk,
   input  wire logic                     sys_rst,
   input  wire logic                     clk_en,
   input  wire logic [ebt_pkg::AW-1:0]   reg_addr,
   input  wire logic [ebt_pkg::DW-1:0]   reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic      [ebt_pkg::DW-1:0]   reg_rdata,
   output logic                          irq,
   input  wire logic                     capture_input_one,
   input  wire logic                     capture_input_two,
   output logic                          match_output_one,
   output logic                          match_output_one_oe,
   output logic                          match_output_two,
   output logic                          match_output_two_oe
);
   import ebt_pkg::*;

   localparam int unsigned PW = (PRESC_DIV > 1) ? $clog2(PRESC_DIV) : 1;
   localparam logic [PW-1:0] PRESC_LAST = PW'(PRESC_DIV - 1);

   typedef struct packed {
      logic [DW-1:0]  cnt;
      logic [PW-1:0]  presc;
      logic [DW-1:0]  cap1;
      logic [DW-1:0]  cap2;
      logic [DW-1:0]  cmp1;
      logic [DW-1:0]  cmp2;
      logic [NEV-1:0] flags;
      logic [NEV-1:0] armed;
      logic           freeze;
      logic           pwm;
      logic [NEV-1:0] ev_st;
      logic [NEV-1:0] ev_en;
      logic           irq;
      logic [DW-1:0]  rdata;
      logic           out1;
      logic           out2;
      logic           oe;
      logic [2:0]     sync1;
      logic [2:0]     sync2;
   } ebt_state_t;

   ebt_state_t s_q;
   ebt_state_t s_d;

   // true when the current bus cycle reads or writes the given offset
   function automatic logic ebt_hit(input logic [AW-1:0] addr,
                                    input logic          acc,
                                    input logic [AW-1:0] off);
      ebt_hit = acc && (addr == off);
   endfunction : ebt_hit

   // register whose access completes the clear sequence of an event
   function automatic logic [AW-1:0] ebt_clr_off(input int unsigned ev);
      logic [AW-1:0] off;
      off = OFF_STATUS;
      case (ev)
         EV_CAP1: off = OFF_CAP1;
         EV_CMP1: off = OFF_CMP1;
         EV_WRAP: off = OFF_MAIN;
         EV_CAP2: off = OFF_CAP2;
         EV_CMP2: off = OFF_CMP2;
         default: off = OFF_STATUS;
      endcase
      ebt_clr_off = off;
   endfunction : ebt_clr_off

   logic           acc;
   logic           st_rd;
   logic           cnt_wr;
   logic           tick;
   logic [DW-1:0]  cnt_nx;
   logic           edge1;
   logic           edge2;
   logic [NEV-1:0] ev_set;
   logic [NEV-1:0] ev_clr;
   logic [NEV-1:0] irq_clr;

   always_comb begin
      s_d = s_q;

      acc   = reg_wr | reg_rd;
      st_rd = ebt_hit(reg_addr, reg_rd, OFF_STATUS);
      // a write to either count register restarts the count
      cnt_wr = ebt_hit(reg_addr, reg_wr, OFF_MAIN) |
               ebt_hit(reg_addr, reg_wr, OFF_ALT);

      // pins pass two flops before the edge detector reads them
      s_d.sync1 = {s_q.sync1[1:0], capture_input_one};
      s_d.sync2 = {s_q.sync2[1:0], capture_input_two};
      edge1 = s_q.sync1[1] & ~s_q.sync1[2];
      edge2 = s_q.sync2[1] & ~s_q.sync2[2];

      // prescaler and count hold while frozen, except that a count register write still reloads them
      tick   = 1'b0;
      cnt_nx = s_q.cnt;
      if (cnt_wr) begin
         s_d.presc = '0;
         cnt_nx    = CNT_RST;
      end else if (!s_q.freeze) begin
         if (s_q.presc == PRESC_LAST) begin
            s_d.presc = '0;
            tick      = 1'b1;
            cnt_nx    = s_q.cnt + 8'h01;
         end else begin
            s_d.presc = s_q.presc + PW'(1);
         end
      end
      s_d.cnt = cnt_nx;

      ev_set = '0;
      if (tick && s_q.cnt == CNT_MAX) begin
         ev_set[EV_WRAP] = 1'b1;
      end
      // matches are judged on the new count, so each value hits once
      if (tick && cnt_nx == s_q.cmp1) begin
         ev_set[EV_CMP1] = 1'b1;
      end
      if (tick && cnt_nx == s_q.cmp2) begin
         ev_set[EV_CMP2] = 1'b1;
         if (s_q.pwm) begin
            ev_set[EV_CAP1] = 1'b1;
         end
      end
      if (edge1) begin
         ev_set[EV_CAP1] = 1'b1;
         s_d.cap1        = s_q.cnt;
      end
      if (edge2) begin
         ev_set[EV_CAP2] = 1'b1;
         s_d.cap2        = s_q.cnt;
      end

      // second step of each clear sequence; the alternate count
      // register has no entry here and so never touches the wrap flag
      for (int unsigned i = 0; i < NEV; i++) begin
         ev_clr[i] = s_q.armed[i] &&
                     ebt_hit(reg_addr, acc, ebt_clr_off(i));
      end

      // set wins over a clear arriving in the same cycle
      s_d.flags = (s_q.flags & ~ev_clr) | ev_set;
      if (st_rd) begin
         s_d.armed = s_q.flags;
      end else begin
         // a fresh event disarms its flag, so it survives the sequence
         s_d.armed = s_q.armed & ~ev_clr & ~ev_set;
      end

      // register writes stay open while frozen
      irq_clr = '0;
      if (reg_wr) begin
         unique case (reg_addr)
            OFF_STATUS: s_d.freeze = reg_wdata[FREEZE_BIT];
            OFF_CMP1:   s_d.cmp1   = reg_wdata;
            OFF_CMP2:   s_d.cmp2   = reg_wdata;
            OFF_CTRL:   s_d.pwm    = reg_wdata[PWM_BIT];
            OFF_IRQ_EN: s_d.ev_en  = reg_wdata[FLAG_LSB +: NEV];
            OFF_IRQ_CL: irq_clr    = reg_wdata[FLAG_LSB +: NEV];
            default:    ;
         endcase
      end

      // interrupt status: sticky, set beats the write-one clear
      s_d.ev_st = (s_q.ev_st & ~irq_clr) | ev_set;
      s_d.irq   = |(s_d.ev_st & s_d.ev_en);

      // read data stand only in the cycle after the read strobe
      s_d.rdata = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            OFF_STATUS: s_d.rdata = {s_q.flags, s_q.freeze, 2'b00};
            OFF_CAP1:   s_d.rdata = s_q.cap1;
            OFF_CMP1:   s_d.rdata = s_q.cmp1;
            OFF_CMP2:   s_d.rdata = s_q.cmp2;
            OFF_MAIN:   s_d.rdata = s_q.cnt;
            OFF_ALT:    s_d.rdata = s_q.cnt;
            OFF_CAP2:   s_d.rdata = s_q.cap2;
            OFF_CTRL:   s_d.rdata = {7'h00, s_q.pwm};
            OFF_IRQ_ST: s_d.rdata = {s_q.ev_st, 3'b000};
            OFF_IRQ_EN: s_d.rdata = {s_q.ev_en, 3'b000};
            default:    s_d.rdata = '0;
         endcase
      end

      // outputs: toggle on match, or out1 in pwm mode high from the wrap to
      // the compare one match; forced low and released while frozen
      if (s_d.freeze) begin
         s_d.out1 = 1'b0;
         s_d.out2 = 1'b0;
         s_d.oe   = 1'b0;
      end else begin
         s_d.oe = 1'b1;
         if (s_q.pwm) begin
            if (ev_set[EV_CMP1]) begin
               s_d.out1 = 1'b0;
            end else if (ev_set[EV_WRAP]) begin
               s_d.out1 = 1'b1;
            end
         end else if (ev_set[EV_CMP1]) begin
            s_d.out1 = ~s_q.out1;
         end
         if (ev_set[EV_CMP2]) begin
            s_d.out2 = ~s_q.out2;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s_q        <= '0;
         s_q.cnt    <= CNT_RST;
         s_q.cmp1   <= CMP_RST;
         s_q.cmp2   <= CMP_RST;
         s_q.flags  <= STATUS_RST[FLAG_LSB +: NEV];
         s_q.freeze <= STATUS_RST[FREEZE_BIT];
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign reg_rdata           = s_q.rdata;
   assign irq                 = s_q.irq;
   assign match_output_one    = s_q.out1;
   assign match_output_two    = s_q.out2;
   assign match_output_one_oe = s_q.oe;
   assign match_output_two_oe = s_q.oe;

endmodule : ebt_timer

//--- tb/ebt_pin_model.sv
// outside world driving the two capture pins
`timescale 1ns/100ps
module ebt_pin_model (
   input  wire logic ref_clk,
   output logic      capture_input_one,
   output logic      capture_input_two
);
   initial begin
      capture_input_one = 1'b0;
      capture_input_two = 1'b0;
   end
   // held three clocks so the synchroniser cannot miss the edge
   task automatic pulse(input int ch);
      @(posedge ref_clk);
      capture_input_one <= (ch == 1);
      capture_input_two <= (ch == 2);
      repeat (3) @(posedge ref_clk);
      capture_input_one <= 1'b0;
      capture_input_two <= 1'b0;
   endtask : pulse
endmodule : ebt_pin_model

//--- tb/ebt_timer_asserts.sv
// port-level checks of the capture/compare timer
`timescale 1ns/100ps
module ebt_timer_asserts (
   input wire logic                   ref_clk,
   input wire logic                   sys_rst,
   input wire logic [ebt_pkg::AW-1:0] reg_addr,
   input wire logic [ebt_pkg::DW-1:0] reg_wdata,
   input wire logic                   reg_wr,
   input wire logic                   reg_rd,
   input wire logic [ebt_pkg::DW-1:0] reg_rdata,
   input wire logic                   irq,
   input wire logic                   match_output_one_oe,
   input wire logic                   match_output_two_oe
);
   import ebt_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence st_rd;
      reg_rd && reg_addr == OFF_STATUS;
   endsequence
   AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   AST_STATUS_RSVD: assert property (
      $past(reg_rd) && $past(reg_addr) == OFF_STATUS |-> reg_rdata[1:0] == 2'b00)
      else $error("status reserved bits not zero");
   AST_FREEZE_OE: assert property (
      reg_wr && reg_addr == OFF_STATUS && reg_wdata[FREEZE_BIT]
      ##1 !(reg_wr && reg_addr == OFF_STATUS)
      |=> !match_output_one_oe && !match_output_two_oe)
      else $error("outputs still driven after freeze");
   AST_FROZEN_OE: assert property (
      $past(reg_rd) && $past(reg_addr) == OFF_STATUS && reg_rdata[FREEZE_BIT]
      |-> !(match_output_one_oe || match_output_two_oe))
      else $error("outputs driven while frozen");
   AST_FROZEN_COUNT: assert property (
      st_rd ##1 (reg_rdata[FREEZE_BIT] && reg_rd && reg_addr == OFF_MAIN)
      ##1 (reg_rd && reg_addr == OFF_MAIN) |=> $stable(reg_rdata))
      else $error("count moved while frozen");
   AST_COUNT_RELOAD: assert property (
      reg_wr && (reg_addr == OFF_MAIN || reg_addr == OFF_ALT)
      ##1 (reg_rd && reg_addr == OFF_MAIN) |=> reg_rdata == CNT_RST)
      else $error("count not reloaded by write");
   AST_CMP_RW: assert property (
      reg_wr && (reg_addr == OFF_CMP1 || reg_addr == OFF_CMP2)
      ##1 (reg_rd && $stable(reg_addr)) |=> reg_rdata == $past(reg_wdata, 2))
      else $error("compare register readback wrong");
   AST_ALT_KEEPS_WRAP: assert property (
      st_rd ##1 (reg_rdata[EV_WRAP+FLAG_LSB] && reg_rd && reg_addr == OFF_ALT)
      ##1 st_rd |=> reg_rdata[EV_WRAP+FLAG_LSB])
      else $error("alternate count access cleared wrap flag");
   AST_IRQ_MASKED: assert property (
      $past(reg_rd) && $past(reg_addr) == OFF_IRQ_EN && reg_rdata == 8'h00
      |-> !irq)
      else $error("interrupt high with nothing enabled");
   CV_FROZEN: cover property (st_rd ##1 reg_rdata[FREEZE_BIT]);
   CV_WRAP: cover property (st_rd ##1 reg_rdata[EV_WRAP+FLAG_LSB]);
   CV_IRQ: cover property ($rose(irq));
endmodule : ebt_timer_asserts

bind ebt_timer ebt_timer_asserts u_chk (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .irq(irq),
   .match_output_one_oe(match_output_one_oe),
   .match_output_two_oe(match_output_two_oe));

//--- tb/ebt_timer_tb_top.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/100ps
module ebt_timer_tb_top;
   import ebt_pkg::*;
   logic          ref_clk = 1'b0;
   logic          sys_rst = 1'b1;
   logic [AW-1:0] reg_addr = 4'h0;
   logic [DW-1:0] reg_wdata = 8'h00;
   logic          reg_wr = 1'b0;
   logic          reg_rd = 1'b0;
   logic [DW-1:0] reg_rdata;
   logic          irq, cap_one, cap_two, m_one, m_one_oe, m_two, m_two_oe;
   int            n_mismatch = 0;
   int            num_checks = 0;
   int            cyc = 0;

   // prescaler of 1 keeps a full wrap within 256 cycles
   ebt_timer #(.PRESC_DIV(1)) uut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .capture_input_one(cap_one), .capture_input_two(cap_two),
      .match_output_one(m_one), .match_output_one_oe(m_one_oe),
      .match_output_two(m_two), .match_output_two_oe(m_two_oe));
   ebt_pin_model u_pins (.ref_clk(ref_clk), .capture_input_one(cap_one),
      .capture_input_two(cap_two));

   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // strobes stay up between calls so accesses run back to back
   task automatic acc(input logic w, input logic [AW-1:0] a,
                      input logic [DW-1:0] d);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      #1;
   endtask : acc
   task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] m,
                      input logic [DW-1:0] e);
      acc(1'b0, a, 8'h00);
      chk(reg_rdata & m, e);
   endtask : rdc
   task automatic idle(input int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : idle

   task automatic t_reset;
      rdc(OFF_STATUS, 8'hFF, STATUS_RST);
      rdc(OFF_CMP1, 8'hFF, CMP_RST);
      rdc(OFF_CMP2, 8'hFF, CMP_RST);
      rdc(4'hF, 8'hFF, 8'h00);
      idle(1);
   endtask : t_reset
   task automatic t_capture;
      acc(1'b1, OFF_STATUS, 8'h04);
      acc(1'b1, OFF_MAIN, 8'h33);
      idle(1);
      u_pins.pulse(1);
      u_pins.pulse(2);
      idle(6);
      rdc(OFF_STATUS, 8'h94, 8'h94);
      rdc(OFF_MAIN, 8'hFF, CNT_RST);
      rdc(OFF_MAIN, 8'hFF, CNT_RST);
      rdc(OFF_CAP2, 8'hFF, CNT_RST);
      acc(1'b1, OFF_CAP1, 8'h5A);
      rdc(OFF_CAP1, 8'hFF, CNT_RST);
      rdc(OFF_STATUS, 8'h94, 8'h04);
      idle(1);
      u_pins.pulse(1);
      idle(6);
      rdc(OFF_CAP1, 8'hFF, CNT_RST);
      rdc(OFF_STATUS, 8'h80, 8'h80);
      rdc(OFF_CAP1, 8'hFF, CNT_RST);
      rdc(OFF_STATUS, 8'h80, 8'h00);
      idle(1);
   endtask : t_capture
   task automatic t_wrap;
      acc(1'b1, OFF_STATUS, 8'h00);
      acc(1'b1, OFF_MAIN, 8'h00);
      rdc(OFF_MAIN, 8'hFF, CNT_RST);
      idle(10);
      rdc(OFF_STATUS, 8'h68, 8'h68);
      acc(1'b0, OFF_ALT, 8'h00);
      rdc(OFF_STATUS, 8'h20, 8'h20);
      acc(1'b0, OFF_MAIN, 8'h00);
      acc(1'b1, OFF_CMP1, 8'h80);
      rdc(OFF_CMP1, 8'hFF, 8'h80);
      acc(1'b0, OFF_CMP2, 8'h00);
      rdc(OFF_STATUS, 8'h68, 8'h00);
      idle(140);
      rdc(OFF_STATUS, 8'h40, 8'h40);
      idle(1);
   endtask : t_wrap
   task automatic t_irq;
      acc(1'b1, OFF_IRQ_CL, 8'hF8);
      acc(1'b1, OFF_IRQ_EN, 8'h20);
      idle(3);
      chk({7'h00, irq}, 8'h00);
      acc(1'b1, OFF_MAIN, 8'h00);
      idle(8);
      chk({7'h00, irq}, 8'h01);
      acc(1'b1, OFF_IRQ_EN, 8'h00);
      rdc(OFF_IRQ_EN, 8'hFF, 8'h00);
      idle(2);
      chk({7'h00, irq}, 8'h00);
      acc(1'b1, OFF_IRQ_EN, 8'h20);
      idle(2);
      chk({7'h00, irq}, 8'h01);
      acc(1'b1, OFF_IRQ_CL, 8'h20);
      idle(2);
      chk({7'h00, irq}, 8'h00);
   endtask : t_irq
   // pwm mode: a compare two match raises capture flag one, out1 rises
   // on the wrap; freezing then drops both outputs and their enables
   task automatic t_pwm;
      acc(1'b1, OFF_CTRL, 8'h01);
      acc(1'b1, OFF_CMP2, 8'h02);
      acc(1'b1, OFF_MAIN, 8'h00);
      idle(10);
      rdc(OFF_STATUS, 8'h80, 8'h80);
      chk({7'h00, m_one}, 8'h01);
      chk({7'h00, m_one_oe}, 8'h01);
      chk({7'h00, m_two_oe}, 8'h01);
      acc(1'b1, OFF_STATUS, 8'h04);
      idle(2);
      chk({7'h00, m_one}, 8'h00);
      chk({7'h00, m_two}, 8'h00);
      chk({7'h00, m_one_oe}, 8'h00);
      chk({7'h00, m_two_oe}, 8'h00);
      acc(1'b1, OFF_STATUS, 8'h00);
      acc(1'b1, OFF_CTRL, 8'h00);
      idle(1);
   endtask : t_pwm

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   initial begin
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      #1;
      t_reset();
      t_capture();
      t_wrap();
      t_irq();
      t_pwm();
      print_verdict();
   end
endmodule : ebt_timer_tb_top
